//--- hdl/wwdt_pkg.sv
// shared constants of the window watchdog register block
package wwdt_pkg;
	// register byte offsets
	localparam logic [7:0]  WWDT_OFS_RELOAD  = 8'h00;
	localparam logic [7:0]  WWDT_OFS_CTRL    = 8'h04;
	localparam logic [7:0]  WWDT_OFS_STATUS  = 8'h08;
	localparam logic [7:0]  WWDT_OFS_COUNT   = 8'h0c;
	localparam logic [7:0]  WWDT_OFS_MASK    = 8'h10;
	// control field positions
	localparam int          WWDT_CTRL_EN_BIT  = 0;
	localparam int          WWDT_CTRL_IE_BIT  = 1;
	localparam int          WWDT_CTRL_PS_LSB  = 8;
	localparam int          WWDT_CTRL_CMP_LSB = 16;
	localparam int          WWDT_CTRL_DBG_BIT = 31;
	localparam logic [31:0] WWDT_CTRL_WMASK   = 32'h803f_0f03;
	// status field positions
	localparam int          WWDT_ST_MATCH_BIT = 0;
	localparam int          WWDT_ST_RESET_BIT = 1;
	// reset values
	localparam logic [31:0] WWDT_CTRL_RST     = 32'h003f_0800;
	localparam logic [1:0]  WWDT_STATUS_RST   = 2'h0;
	localparam logic [1:0]  WWDT_MASK_RST     = 2'h0;
	localparam logic [5:0]  WWDT_COUNT_RST    = 6'h3f;
	localparam logic [10:0] WWDT_PCNT_RST     = 11'h0bf;
	// reload key and counter top
	localparam logic [31:0] WWDT_RELOAD_KEY   = 32'h0000_5aa5;
	localparam logic [5:0]  WWDT_COUNT_TOP    = 6'h3f;
	// watchdog clocks needed to carry a reload command over
	localparam logic [1:0]  WWDT_RELOAD_SYNC  = 2'h3;
	// prescale divide per select code
	localparam logic [11:0] WWDT_PRESCALE [16] = '{
		12'h001, 12'h002, 12'h004, 12'h008, 12'h010, 12'h020, 12'h040, 12'h080,
		12'h0c0, 12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h600, 12'h800
	};
endpackage

//--- hdl/wwdt_pre_if.sv
// link between the watchdog core and its prescaler
`timescale 1ns/1ps
interface wwdt_pre_if;
	logic       tick;
	logic       restart;
	logic [3:0] sel;
	logic       expire;
	logic       pzero;
	modport ctl (output tick, output restart, output sel, input expire, input pzero);
	modport pre (input tick, input restart, input sel, output expire, output pzero);
endinterface

//--- hdl/wwdt_prescale.sv
// prescale counter between watchdog clock ticks and counter steps
`timescale 1ns/1ps
module wwdt_prescale
	import wwdt_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	wwdt_pre_if.pre   pre_io
);
	typedef struct packed {
		logic [10:0] pcnt;
	} wwdt_pre_state_type;

	wwdt_pre_state_type s_q;
	wwdt_pre_state_type s_d;
	logic [10:0]        load;

	assign load          = 11'(WWDT_PRESCALE[pre_io.sel] - 12'h001);
	assign pre_io.pzero  = (s_q.pcnt == 11'h000);
	assign pre_io.expire = pre_io.tick && pre_io.pzero && !pre_io.restart;

	always_comb begin
		s_d = s_q;
		if (pre_io.restart) begin
			s_d.pcnt = load;
		end else if (pre_io.tick) begin
			s_d.pcnt = pre_io.pzero ? load : 11'(s_q.pcnt - 11'h001);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q.pcnt <= WWDT_PCNT_RST;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end
endmodule

//--- hdl/wwdt_core.sv
// window watchdog with wishbone register access
// Function
// - key write to reload register reloads the counter to 0x3F
// - key write above the window compare raises system reset at once
// - control register takes one write after reset, later writes ignored
// - debug-halt bit clear: counter frozen while CPU is halted
// - debug-halt bit set: counter keeps running during CPU halt
// - window compare field bits 21:16 bounds the permitted reload range
// - prescale select bits 11:8 picks divide; timeout is divide times 64
// - control register resets to 0x003F_0800
// - counter value register at 0x0C is read-only live count, resets 0x3F
// - status register at 0x08 is read/write and resets to zero
// - reload register at 0x00 is write-only, 32 bits, resets zero
// - enabled counter steps down from 0x3F once per prescaler expiry
// - count equal to window compare sets match flag, interrupt if enabled
// - counter at zero and prescaler at zero raises system reset
// - reload takes 3 watchdog clocks before counter returns to 0x3F
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module wwdt_core
	import wwdt_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        watchdog_clock_i,
	input  wire logic        cpu_halted_i,
	output logic             sys_rst_o,
	output logic             irq_o
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic        written;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic [5:0]  count;
		logic        pend;
		logic [1:0]  pend_cnt;
		logic        rst_out;
		logic        ack;
		logic [31:0] rdat;
		logic        wd_s1;
		logic        wd_s2;
		logic        wd_s3;
		logic        halt_s1;
		logic        halt_s2;
	} wwdt_state_type;

	localparam wwdt_state_type WWDT_S_RST = '{
		ctrl:     WWDT_CTRL_RST,
		written:  1'b0,
		status:   WWDT_STATUS_RST,
		mask:     WWDT_MASK_RST,
		count:    WWDT_COUNT_RST,
		pend:     1'b0,
		pend_cnt: 2'h0,
		rst_out:  1'b0,
		ack:      1'b0,
		rdat:     32'h0000_0000,
		wd_s1:    1'b0,
		wd_s2:    1'b0,
		wd_s3:    1'b0,
		halt_s1:  1'b0,
		halt_s2:  1'b0
	};

	wwdt_state_type s_q;
	wwdt_state_type s_d;
	wwdt_pre_if     pre_bus ();

	logic [7:0]  adr;
	logic        acc;
	logic        acc_wr;
	logic        acc_rd;
	logic        key_wr;
	logic        ctrl_wr_ok;
	logic [5:0]  cmp;
	logic        enabled;
	logic        freeze;
	logic        wd_edge;
	logic        tick_run;
	logic        reload_now;
	logic [31:0] wmask;
	logic [31:0] rd_mux;

	assign adr      = {wb_adr_i[7:2], 2'b00};
	// effects land on the edge where the master samples ack
	assign acc      = wb_cyc_i && wb_stb_i && s_q.ack;
	assign acc_wr   = acc && wb_we_i;
	assign acc_rd   = acc && !wb_we_i;
	assign key_wr   = acc_wr && adr == WWDT_OFS_RELOAD && wb_dat_i == WWDT_RELOAD_KEY;
	assign ctrl_wr_ok = acc_wr && adr == WWDT_OFS_CTRL && !s_q.written;
	assign cmp      = s_q.ctrl[WWDT_CTRL_CMP_LSB +: 6];
	assign enabled  = s_q.ctrl[WWDT_CTRL_EN_BIT];
	assign freeze   = s_q.halt_s2 && !s_q.ctrl[WWDT_CTRL_DBG_BIT];
	assign wd_edge  = s_q.wd_s2 && !s_q.wd_s3;
	assign tick_run = wd_edge && enabled && !freeze && !s_q.rst_out;
	// reload lands on the third watchdog clock
	assign reload_now = tick_run && s_q.pend && s_q.pend_cnt == WWDT_RELOAD_SYNC - 2'h1;

	assign pre_bus.tick    = tick_run;
	assign pre_bus.restart = ctrl_wr_ok || reload_now;
	// the divider restarts on the control write, so it must load the divide being written
	assign pre_bus.sel     = (ctrl_wr_ok && wb_sel_i[1]) ? wb_dat_i[WWDT_CTRL_PS_LSB +: 4]
		: s_q.ctrl[WWDT_CTRL_PS_LSB +: 4];

	wwdt_prescale u_pre (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.pre_io (pre_bus)
	);

	always_comb begin
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		rd_mux = 32'h0000_0000;
		case (adr)
			WWDT_OFS_CTRL: begin
				rd_mux = s_q.ctrl;
			end
			WWDT_OFS_STATUS: begin
				rd_mux = {30'h0000_0000, s_q.status};
			end
			WWDT_OFS_COUNT: begin
				rd_mux = {26'h000_0000, s_q.count};
			end
			WWDT_OFS_MASK: begin
				rd_mux = {30'h0000_0000, s_q.mask};
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		s_d = s_q;
		// pins from outside pass two flip-flops first
		s_d.wd_s1   = watchdog_clock_i;
		s_d.wd_s2   = s_q.wd_s1;
		s_d.wd_s3   = s_q.wd_s2;
		s_d.halt_s1 = cpu_halted_i;
		s_d.halt_s2 = s_q.halt_s1;

		// one wait state; ack drops the cycle after it is given
		s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
		if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
			s_d.rdat = rd_mux;
		end

		if (ctrl_wr_ok) begin
			s_d.ctrl    = (s_q.ctrl & ~(wmask & WWDT_CTRL_WMASK)) | (wb_dat_i & wmask & WWDT_CTRL_WMASK);
			s_d.written = 1'b1;
		end
		if (acc_wr && adr == WWDT_OFS_MASK && wb_sel_i[0]) begin
			s_d.mask = wb_dat_i[1:0];
		end

		// status clears by writing ones or by reading
		if (acc_wr && adr == WWDT_OFS_STATUS && wb_sel_i[0]) begin
			s_d.status = s_q.status & ~wb_dat_i[1:0];
		end
		// clear only what the read returned, so a flag raised after the capture survives
		if (acc_rd && adr == WWDT_OFS_STATUS) begin
			s_d.status = s_d.status & ~s_q.rdat[1:0];
		end

		if (tick_run && s_q.pend) begin
			s_d.pend_cnt = 2'(s_q.pend_cnt + 2'h1);
		end

		// software's window is checked, not trusted
		if (key_wr) begin
			if (s_q.count > cmp) begin
				s_d.rst_out = 1'b1;
			end else if (!s_q.pend) begin
				s_d.pend     = 1'b1;
				s_d.pend_cnt = 2'h0;
			end
		end
		// a wrong key falls through untouched

		if (reload_now) begin
			s_d.count = WWDT_COUNT_TOP;
			s_d.pend  = 1'b0;
		end else if (pre_bus.expire) begin
			if (s_q.count == 6'h00) begin
				s_d.rst_out = 1'b1;
			end else begin
				s_d.count = 6'(s_q.count - 6'h01);
			end
		end

		// match flag on arrival at the compare value; set beats clear
		if (s_d.count != s_q.count && s_d.count == cmp) begin
			s_d.status[WWDT_ST_MATCH_BIT] = 1'b1;
		end
		if (s_d.rst_out && !s_q.rst_out) begin
			s_d.status[WWDT_ST_RESET_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= WWDT_S_RST;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign wb_ack_o  = s_q.ack;
	assign wb_dat_o  = s_q.rdat;
	// reset holds until the system reset comes back in on rst_i
	assign sys_rst_o = s_q.rst_out;
	// match interrupt needs its enable bit
	assign irq_o = (s_q.status[WWDT_ST_MATCH_BIT] && s_q.mask[WWDT_ST_MATCH_BIT] && s_q.ctrl[WWDT_CTRL_IE_BIT])
		|| (s_q.status[WWDT_ST_RESET_BIT] && s_q.mask[WWDT_ST_RESET_BIT]);

	property p_key_reload;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && reload_now |=> s_q.count == WWDT_COUNT_TOP && !s_q.pend;
	endproperty
	a_key_reload: assert property (p_key_reload) else $error("keyed reload did not restore count");

	property p_sync_delay;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && key_wr && s_q.count <= cmp && !s_q.pend && !reload_now |=> s_q.pend && s_q.pend_cnt == 2'h0;
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("reload did not start its sync");

	property p_early_reset;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && key_wr && s_q.count > cmp |=> sys_rst_o;
	endproperty
	a_early_reset: assert property (p_early_reset) else $error("early refresh gave no reset");

	property p_ctrl_once;
		@(posedge clk_i) disable iff (rst_i)
		s_q.written |=> $stable(s_q.ctrl);
	endproperty
	a_ctrl_once: assert property (p_ctrl_once) else $error("control changed after its one write");

	property p_halt_freeze;
		@(posedge clk_i) disable iff (rst_i)
		freeze |=> $stable(s_q.count) || $past(key_wr);
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("count moved during debug halt");

	property p_count_step;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && pre_bus.expire && s_q.count != 6'h00 && !reload_now |=> s_q.count == 6'($past(s_q.count) - 6'h01);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step down by one");

	property p_match_flag;
		@(posedge clk_i) disable iff (rst_i)
		$changed(s_q.count) && s_q.count == cmp |-> s_q.status[WWDT_ST_MATCH_BIT];
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match flag missing at compare");

	property p_timeout;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && pre_bus.expire && s_q.count == 6'h00 && !reload_now |=> sys_rst_o ##1 sys_rst_o;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout gave no held reset");

	property p_count_read;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && !wb_we_i && adr == WWDT_OFS_COUNT && $past(ce_i) |-> wb_dat_o == {26'h000_0000, $past(s_q.count)};
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read shows wrong value");

	property p_bad_key;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && acc_wr && adr == WWDT_OFS_RELOAD && wb_dat_i != WWDT_RELOAD_KEY && !s_q.pend |=> !s_q.pend;
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("wrong key started a reload");

	c_reload: cover property (@(posedge clk_i) disable iff (rst_i) reload_now);
	c_early:  cover property (@(posedge clk_i) disable iff (rst_i) key_wr && s_q.count > cmp);
	c_irq:    cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
	c_tmo:    cover property (@(posedge clk_i) disable iff (rst_i) pre_bus.expire && s_q.count == 6'h00);
endmodule

//--- bench/tb_window_watchdog_registers.sv
// self-checking bench for the window watchdog register block
`timescale 1ns/1ps
module tb_window_watchdog_registers;
	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic        halt    = 1'b0;
	logic        ce      = 1'b1;
	logic [7:0]  adr     = 8'h00;
	logic [3:0]  sel     = 4'hf;
	logic [31:0] wdat    = 32'h0000_0000;
	logic [31:0] rd;
	logic [31:0] keep;
	logic [2:0]  div     = 3'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        sys_rst_o;
	logic        irq_o;
	int          err_total = 0;
	int          tests_run = 0;

	always #2.5 clk_i = ~clk_i;

	// watchdog clock is eight system clocks, slow enough for the pin synchronisers
	always @(posedge clk_i) begin
		div <= div + 3'h1;
	end

	wwdt_core dut (
		.clk_i            (clk_i),
		.rst_i            (rst_i),
		.ce_i             (ce),
		.wb_cyc_i         (cyc),
		.wb_stb_i         (stb),
		.wb_we_i          (we),
		.wb_adr_i         (adr),
		.wb_sel_i         (sel),
		.wb_dat_i         (wdat),
		.wb_dat_o         (wb_dat_o),
		.wb_ack_o         (wb_ack_o),
		.watchdog_clock_i (div[2]),
		.cpu_halted_i     (halt),
		.sys_rst_o        (sys_rst_o),
		.irq_o            (irq_o)
	);

	task finish_test;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task timeout_hit;
		err_total++;
		$display("[ERR] %0t wait ran out", $time);
		finish_test();
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle; the request stands until ack is seen at a rising edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			timeout_hit();
		end
		@(posedge clk_i);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task do_reset;
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task wait_hi(input logic on_rst, input int lim);
		int k;
		k = 0;
		while (((on_rst ? sys_rst_o : irq_o) !== 1'b1) && k < lim) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= lim) begin
			timeout_hit();
		end
	endtask

	task poll_cnt(input logic [5:0] v);
		int k;
		k = 0;
		do begin
			wb(1'b0, 8'h0c, 32'h0000_0000);
			k++;
		end while (rd[5:0] !== v && k < 300);
		if (k >= 300) begin
			timeout_hit();
		end
	endtask

	initial begin
		do_reset();
		rd_chk(8'h04, 32'h003f_0800);
		rd_chk(8'h08, 32'h0000_0000);
		rd_chk(8'h0c, 32'h0000_003f);
		rd_chk(8'h00, 32'h0000_0000);
		rd_chk(8'h14, 32'h0000_0000);
		wb(1'b1, 8'h0c, 32'h0000_0000);
		rd_chk(8'h0c, 32'h0000_003f);
		// enable, irq enable, divide 2, window at 0x20
		wb(1'b1, 8'h04, 32'h0020_0103);
		wb(1'b1, 8'h04, 32'h803f_0f00);
		rd_chk(8'h04, 32'h0020_0103);
		wb(1'b1, 8'h00, 32'h0000_5aa4);
		chk({31'h0, sys_rst_o}, 32'h0);
		wb(1'b1, 8'h10, 32'h0000_0001);
		wait_hi(1'b0, 2000);
		wb(1'b0, 8'h0c, 32'h0000_0000);
		chk({31'h0, rd <= 32'h20 && rd > 32'h18}, 32'h1);
		wb(1'b1, 8'h10, 32'h0000_0000);
		chk({31'h0, irq_o}, 32'h0);
		wb(1'b1, 8'h10, 32'h0000_0001);
		chk({31'h0, irq_o}, 32'h1);
		wb(1'b0, 8'h08, 32'h0000_0000);
		chk(rd & 32'h1, 32'h1);
		chk({31'h0, irq_o}, 32'h0);
		wb(1'b1, 8'h00, 32'h0000_5aa5);
		wb(1'b0, 8'h0c, 32'h0000_0000);
		chk({31'h0, rd == 32'h3f}, 32'h0);
		poll_cnt(6'h3f);
		chk({31'h0, sys_rst_o}, 32'h0);
		// count 0x3f is above the window, so a key now is too early
		wb(1'b1, 8'h00, 32'h0000_5aa5);
		@(posedge clk_i);
		chk({31'h0, sys_rst_o}, 32'h1);
		rd_chk(8'h08, 32'h0000_0002);
		rd_chk(8'h08, 32'h0000_0000);
		do_reset();
		chk({31'h0, sys_rst_o}, 32'h0);
		halt <= 1'b1;
		wb(1'b1, 8'h04, 32'h003f_0101);
		repeat (150) @(posedge clk_i);
		rd_chk(8'h0c, 32'h0000_003f);
		halt <= 1'b0;
		repeat (150) @(posedge clk_i);
		wb(1'b0, 8'h0c, 32'h0000_0000);
		chk({31'h0, rd < 32'h3f}, 32'h1);
		do_reset();
		halt <= 1'b1;
		wb(1'b1, 8'h04, 32'h803f_0101);
		repeat (150) @(posedge clk_i);
		wb(1'b0, 8'h0c, 32'h0000_0000);
		chk({31'h0, rd < 32'h3f}, 32'h1);
		// clock enable low holds the count; at most one step fits around the pause
		keep = rd;
		ce <= 1'b0;
		repeat (100) @(posedge clk_i);
		ce <= 1'b1;
		wb(1'b0, 8'h0c, 32'h0000_0000);
		chk({31'h0, (keep - rd) <= 32'h1}, 32'h1);
		halt <= 1'b0;
		do_reset();
		// divide 1: 64 watchdog clocks of 8 cycles before expiry
		wb(1'b1, 8'h04, 32'h003f_0001);
		repeat (400) @(posedge clk_i);
		chk({31'h0, sys_rst_o}, 32'h0);
		wait_hi(1'b1, 300);
		wb(1'b1, 8'h10, 32'h0000_0002);
		chk({31'h0, irq_o}, 32'h1);
		wb(1'b1, 8'h08, 32'h0000_0002);
		chk({31'h0, irq_o}, 32'h0);
		for (int i = 0; i < 16; i++) begin
			do_reset();
			wb(1'b1, 8'h04, 32'h003f_0000 | (i << 8));
			rd_chk(8'h04, 32'h003f_0000 | (i << 8));
		end
		finish_test();
	end
endmodule
